// ==== design/daa_ctrl_pkg.sv ====
// constants shared by the control-two / interrupt-mask block
// assumes a 25 MHz system clock and 8-bit register data
package daa_ctrl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_TWO  = 8'h02;  // pin mode, watchdog, paths
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h03;  // per-source mask
  localparam logic [7:0] ADDR_IRQ_SOURCE   = 8'h04;  // sticky source flags
  localparam logic [7:0] ADDR_LINE_CONTROL = 8'h05;  // holds offhook_ctrl

  // ---------------------------------------------------------------
  // control_two fields
  // ---------------------------------------------------------------
  localparam int BIT_IRQ_PIN_SELECT  = 7;
  localparam int BIT_IRQ_ACTIVE_HIGH = 6;
  localparam int BIT_WATCHDOG_ON     = 4;
  localparam int BIT_RING_IRQ_MODE   = 2;
  localparam int BIT_HYBRID_CONNECT  = 1;
  localparam int BIT_RECEIVE_PATH_ON = 0;
  localparam int BIT_OFFHOOK_CTRL    = 0;  // in line control register

  // ---------------------------------------------------------------
  // source flag / mask positions (same layout in both registers)
  // ---------------------------------------------------------------
  localparam int SRC_RING     = 7;
  localparam int SRC_OVERLOAD = 6;
  localparam int SRC_FRAME    = 5;
  localparam int SRC_BILLING  = 4;
  localparam int SRC_DROPOUT  = 3;
  localparam int SRC_LOOP_SAT = 2;
  localparam int SRC_TIP_GND  = 1;
  localparam int SRC_POLARITY = 0;
  localparam int NUM_SOURCES  = 8;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK    = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  localparam int         CLK_HZ          = 25_000_000;
  localparam int         WDOG_TIME_S     = 4;
  localparam int         WDOG_CYCLES     = WDOG_TIME_S * CLK_HZ;

endpackage

// ==== design/daa_flag_bank.sv ====
// sticky event flags: hardware sets, host clears by writing 0
// assumes set and clear vectors are single-cycle, same clock
`timescale 1ns/1ps
`default_nettype none

module daa_flag_bank #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // event and clear strobes
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clr,
  // flag state
  output logic      [WIDTH-1:0] o_flags
);

  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] flags_reg;  // sticky bits
  logic [WIDTH-1:0] flags_next; // next value

  // set beats clear so an event in the clear cycle is kept
  always_comb begin
    flags_next = (flags_reg & ~i_clr) | i_set;
  end

  // flags drop only on reset or host clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule // daa_flag_bank

`default_nettype wire

// ==== design/daa_watchdog.sv ====
// register-access watchdog counter
// assumes kick is a one-cycle pulse per register access
`timescale 1ns/1ps
`default_nettype none

module daa_watchdog #(
  parameter int LIMIT = 100_000_000
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  // control
  input  wire logic i_enable,
  input  wire logic i_kick,
  // timeout event
  output logic      o_timeout
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count_reg;    // idle cycles seen
  logic          timeout_reg;  // one-cycle timeout pulse

  // any access restarts from zero; disabled holds at zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count_reg   <= '0;
      timeout_reg <= 1'b0;
    end else if (!i_enable || i_kick) begin
      count_reg   <= '0;
      timeout_reg <= 1'b0;
    end else if (count_reg == LAST) begin
      // window expired, restart so it repeats every window
      count_reg   <= '0;
      timeout_reg <= 1'b1;
    end else begin
      count_reg   <= count_reg + CW'(1);
      timeout_reg <= 1'b0;
    end
  end

  assign o_timeout = timeout_reg;

endmodule // daa_watchdog

`default_nettype wire

// ==== design/daa_irq_watchdog_control.sv ====
// second control register, interrupt mask, source flags and watchdog
// assumes register strobes and event inputs come from same-clock logic
//
// Behaviour
// - bit 7 picks audio or interrupt pin
// - bit 6 sets interrupt pin polarity
// - watchdog enable sticks until hardware reset
// - four idle seconds clear off-hook
// - any register access restarts watchdog
// - host setting off-hook again resumes it
// - mode 0: one ring interrupt at start
// - mode 1: ring interrupt start and end
// - bit 1 connects hybrid to transmit
// - bit 0 enables receive path
// - mask bit 7 gates ring
// - mask bit 6 gates receive overload
// - mask bit 5 gates frame lock loss
// - mask bit 4 gates billing tone
// - mask bit 3 gates supply dropout
// - mask bit 2 gates loop current saturation
// - mask bit 1 gates tip ground
// - mask bit 0 gates polarity reversal
// - flags stick until host writes 0
`timescale 1ns/1ps
`default_nettype none

module daa_irq_watchdog_control #(
  parameter int WDOG_LIMIT = daa_ctrl_pkg::WDOG_CYCLES,
  parameter int LOOP_W     = 5
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // register port
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // line event inputs
  input  wire logic              i_ring_active,
  input  wire logic              i_rx_overload,
  input  wire logic              i_frame_unlocked,
  input  wire logic              i_billing_tone,
  input  wire logic              i_supply_dropout,
  input  wire logic [LOOP_W-1:0] i_loop_current_field,
  input  wire logic              i_tip_ground_status,
  input  wire logic              i_line_voltage_msb,
  // shared pin and path controls
  output logic                   o_irq_pin_select,
  output logic                   o_shared_audio_irq_pin,
  output logic                   o_hybrid_connect,
  output logic                   o_receive_path_on,
  output logic                   o_offhook_ctrl,
  output logic                   o_watchdog_on
);

  // ---------------------------------------------------------------
  // local helpers
  // ---------------------------------------------------------------
  localparam logic [LOOP_W-1:0] LOOP_SAT = '1;  // all ones

  // address match for a register write
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] reg_addr);
    wr_hit = wr && (addr == reg_addr);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic       irq_pin_select_reg;   // pin carries interrupt
  logic       irq_active_high_reg;  // interrupt polarity
  logic       watchdog_on_reg;      // sticky enable
  logic       ring_irq_mode_reg;    // two interrupts per burst
  logic       hybrid_connect_reg;   // hybrid in transmit path
  logic       receive_path_on_reg;  // receive path enable
  logic [7:0] irq_mask_reg;         // per-source mask
  logic       offhook_ctrl_reg;     // line interface off-hook
  logic [7:0] rdata_reg;            // read answer
  logic       pin_reg;              // shared pin level

  // previous values for edge detection
  logic ring_prev_reg;
  logic tip_prev_reg;
  logic pol_prev_reg;

  // decoded writes
  logic wr_ctrl2;
  logic wr_mask;
  logic wr_src;
  logic wr_line;

  // flag bank wiring
  logic [7:0] src_set;   // event strobes into flags
  logic [7:0] src_clr;   // host clear strobes
  logic [7:0] src_flags; // sticky flag state
  logic       pending;   // any flag passes its mask
  logic       wdog_to;   // watchdog timeout pulse
  logic       access;    // any register access

  assign wr_ctrl2 = wr_hit(i_reg_wr, i_reg_addr, daa_ctrl_pkg::ADDR_CONTROL_TWO);
  assign wr_mask  = wr_hit(i_reg_wr, i_reg_addr, daa_ctrl_pkg::ADDR_IRQ_MASK);
  assign wr_src   = wr_hit(i_reg_wr, i_reg_addr, daa_ctrl_pkg::ADDR_IRQ_SOURCE);
  assign wr_line  = wr_hit(i_reg_wr, i_reg_addr, daa_ctrl_pkg::ADDR_LINE_CONTROL);
  assign access   = i_reg_wr | i_reg_rd;

  // ---------------------------------------------------------------
  // control_two register
  // ---------------------------------------------------------------

  // plain read/write fields of control_two
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      irq_pin_select_reg  <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_IRQ_PIN_SELECT];
      irq_active_high_reg <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_IRQ_ACTIVE_HIGH];
      ring_irq_mode_reg   <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_RING_IRQ_MODE];
      hybrid_connect_reg  <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_HYBRID_CONNECT];
      receive_path_on_reg <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_RECEIVE_PATH_ON];
    end else if (wr_ctrl2) begin
      irq_pin_select_reg  <= i_reg_wdata[daa_ctrl_pkg::BIT_IRQ_PIN_SELECT];
      irq_active_high_reg <= i_reg_wdata[daa_ctrl_pkg::BIT_IRQ_ACTIVE_HIGH];
      ring_irq_mode_reg   <= i_reg_wdata[daa_ctrl_pkg::BIT_RING_IRQ_MODE];
      hybrid_connect_reg  <= i_reg_wdata[daa_ctrl_pkg::BIT_HYBRID_CONNECT];
      receive_path_on_reg <= i_reg_wdata[daa_ctrl_pkg::BIT_RECEIVE_PATH_ON];
    end
  end

  // watchdog enable: a write of 0 is ignored once set, so
  // runaway software cannot switch off its own safety net
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      watchdog_on_reg <= daa_ctrl_pkg::RST_CONTROL_TWO[daa_ctrl_pkg::BIT_WATCHDOG_ON];
    end else if (wr_ctrl2 && i_reg_wdata[daa_ctrl_pkg::BIT_WATCHDOG_ON]) begin
      watchdog_on_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupt mask register
  // ---------------------------------------------------------------

  // each bit gates the flag at the same position
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      irq_mask_reg <= daa_ctrl_pkg::RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_reg <= i_reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // off-hook control and watchdog
  // ---------------------------------------------------------------

  // host write sets or clears; timeout forces on-hook.
  // a line control write in the cycle of the timeout pulse wins over the timeout
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      offhook_ctrl_reg <= 1'b0;
    end else if (wr_line) begin
      offhook_ctrl_reg <= i_reg_wdata[daa_ctrl_pkg::BIT_OFFHOOK_CTRL];
    end else if (wdog_to) begin
      offhook_ctrl_reg <= 1'b0;
    end
  end

  // idle counter, restarted by every read or write
  daa_watchdog #(
    .LIMIT (WDOG_LIMIT)
  ) u_watchdog (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (watchdog_on_reg),
    .i_kick    (access),
    .o_timeout (wdog_to)
  );

  // ---------------------------------------------------------------
  // event edge detection
  // ---------------------------------------------------------------

  // previous samples of level inputs
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ring_prev_reg <= 1'b0;
      tip_prev_reg  <= 1'b0;
      pol_prev_reg  <= 1'b0;
    end else begin
      ring_prev_reg <= i_ring_active;
      tip_prev_reg  <= i_tip_ground_status;
      pol_prev_reg  <= i_line_voltage_msb;
    end
  end

  // event strobes into the flag bank
  always_comb begin
    src_set = '0;
    // burst start always flags; burst end only in two-interrupt mode.
    // if the host left the start flag set, the end adds nothing new
    src_set[daa_ctrl_pkg::SRC_RING] =
      (i_ring_active & ~ring_prev_reg) |
      (ring_irq_mode_reg & ~i_ring_active & ring_prev_reg);
    src_set[daa_ctrl_pkg::SRC_OVERLOAD] = i_rx_overload;
    // frame loss is a level: flag re-sets while lock is missing
    src_set[daa_ctrl_pkg::SRC_FRAME]    = i_frame_unlocked;
    src_set[daa_ctrl_pkg::SRC_BILLING]  = i_billing_tone;
    src_set[daa_ctrl_pkg::SRC_DROPOUT]  = i_supply_dropout;
    src_set[daa_ctrl_pkg::SRC_LOOP_SAT] = (i_loop_current_field == LOOP_SAT);
    src_set[daa_ctrl_pkg::SRC_TIP_GND]  = i_tip_ground_status & ~tip_prev_reg;
    // either direction of the top voltage bit is a reversal
    src_set[daa_ctrl_pkg::SRC_POLARITY] = i_line_voltage_msb ^ pol_prev_reg;
  end

  // writing 0 clears a flag, writing 1 leaves it
  always_comb begin
    src_clr = wr_src ? ~i_reg_wdata : '0;
  end

  // sticky storage
  daa_flag_bank #(
    .WIDTH (daa_ctrl_pkg::NUM_SOURCES)
  ) u_flags (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (src_set),
    .i_clr     (src_clr),
    .o_flags   (src_flags)
  );

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------

  // mask gates every source at its own bit position
  assign pending = |(src_flags & irq_mask_reg);

  // pin held low in audio mode; the audio path drives it then
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_reg <= 1'b0;
    end else if (irq_pin_select_reg) begin
      pin_reg <= irq_active_high_reg ? pending : ~pending;
    end else begin
      pin_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // registered answer one cycle after the read strobe;
  // reserved bits and unmapped offsets read zero
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= daa_ctrl_pkg::READ_ZERO;
    end else if (i_reg_rd) begin
      rdata_reg <= daa_ctrl_pkg::READ_ZERO;
      unique case (i_reg_addr)
        daa_ctrl_pkg::ADDR_CONTROL_TWO: begin
          rdata_reg[daa_ctrl_pkg::BIT_IRQ_PIN_SELECT]  <= irq_pin_select_reg;
          rdata_reg[daa_ctrl_pkg::BIT_IRQ_ACTIVE_HIGH] <= irq_active_high_reg;
          rdata_reg[daa_ctrl_pkg::BIT_WATCHDOG_ON]     <= watchdog_on_reg;
          rdata_reg[daa_ctrl_pkg::BIT_RING_IRQ_MODE]   <= ring_irq_mode_reg;
          rdata_reg[daa_ctrl_pkg::BIT_HYBRID_CONNECT]  <= hybrid_connect_reg;
          rdata_reg[daa_ctrl_pkg::BIT_RECEIVE_PATH_ON] <= receive_path_on_reg;
        end
        daa_ctrl_pkg::ADDR_IRQ_MASK: begin
          rdata_reg <= irq_mask_reg;
        end
        daa_ctrl_pkg::ADDR_IRQ_SOURCE: begin
          rdata_reg <= src_flags;
        end
        daa_ctrl_pkg::ADDR_LINE_CONTROL: begin
          rdata_reg[daa_ctrl_pkg::BIT_OFFHOOK_CTRL] <= offhook_ctrl_reg;
        end
        default: begin
          rdata_reg <= daa_ctrl_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_reg_rdata            = rdata_reg;
  assign o_irq_pin_select       = irq_pin_select_reg;
  assign o_shared_audio_irq_pin = pin_reg;
  assign o_hybrid_connect       = hybrid_connect_reg;
  assign o_receive_path_on      = receive_path_on_reg;
  assign o_offhook_ctrl         = offhook_ctrl_reg;
  assign o_watchdog_on          = watchdog_on_reg;

endmodule // daa_irq_watchdog_control

`default_nettype wire

// ==== testbench/daa_irq_watchdog_control_assertions.sv ====
// checker for the control-two / mask / watchdog block
// sees only the top ports; bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none

module daa_irq_watchdog_control_checker #(
  parameter int WDOG_LIMIT = 100_000_000,
  parameter int LOOP_W     = 5
) (
  // clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  // register port
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        i_reg_addr,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic [7:0]        o_reg_rdata,
  // line events
  input wire logic              i_ring_active,
  input wire logic              i_rx_overload,
  input wire logic              i_frame_unlocked,
  input wire logic              i_billing_tone,
  input wire logic              i_supply_dropout,
  input wire logic [LOOP_W-1:0] i_loop_current_field,
  input wire logic              i_tip_ground_status,
  input wire logic              i_line_voltage_msb,
  // pin and path controls
  input wire logic              o_irq_pin_select,
  input wire logic              o_shared_audio_irq_pin,
  input wire logic              o_hybrid_connect,
  input wire logic              o_receive_path_on,
  input wire logic              o_offhook_ctrl,
  input wire logic              o_watchdog_on
);
  // ---------------------------------------------------------------
  // idle counter: cycles since the last register access
  // ---------------------------------------------------------------
  logic [31:0] idle_cnt;  // saturates so it never wraps
  logic        wr_ctl;    // write to control_two
  assign wr_ctl = i_reg_wr && (i_reg_addr == daa_ctrl_pkg::ADDR_CONTROL_TWO);

  // any access restarts the count, as the watchdog should
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || i_reg_wr || i_reg_rd) begin
      idle_cnt <= 32'h0000_0000;
    end else if (idle_cnt != 32'hFFFF_FFFF) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pin_audio_quiet: assert property (!o_irq_pin_select |=> !o_shared_audio_irq_pin)
    else $error("pin active while in audio mode");
  a_ctl_write_bits: assert property (wr_ctl |=> o_irq_pin_select == $past(i_reg_wdata[7])
    && o_hybrid_connect == $past(i_reg_wdata[1]) && o_receive_path_on == $past(i_reg_wdata[0]))
    else $error("control_two write not reflected");
  a_wdog_set: assert property (wr_ctl && i_reg_wdata[4] |=> o_watchdog_on)
    else $error("watchdog enable not taken");
  a_wdog_sticky: assert property (o_watchdog_on |=> o_watchdog_on)
    else $error("watchdog enable dropped");
  a_offhook_resume: assert property (i_reg_wr && i_reg_addr == daa_ctrl_pkg::ADDR_LINE_CONTROL
    && i_reg_wdata[0] |=> o_offhook_ctrl) else $error("off-hook not resumed");
  a_wdog_not_early: assert property ($fell(o_offhook_ctrl) && !$past(i_sys_rst) &&
    !$past(i_reg_wr) |-> o_watchdog_on && idle_cnt >= WDOG_LIMIT)
    else $error("on-hook forced without idle span");
  a_wdog_not_late: assert property (o_watchdog_on && idle_cnt == WDOG_LIMIT + 5
    |-> !o_offhook_ctrl) else $error("idle span passed without on-hook");
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_read_ctl_bits: assert property (i_reg_rd && i_reg_addr == daa_ctrl_pkg::ADDR_CONTROL_TWO
    |=> o_reg_rdata[7] == $past(o_irq_pin_select) && o_reg_rdata[5] == 1'b0
    && o_reg_rdata[4] == $past(o_watchdog_on) && o_reg_rdata[3] == 1'b0)
    else $error("control_two read wrong");
  a_unmapped_zero: assert property (i_reg_rd && (i_reg_addr < 8'h02 || i_reg_addr > 8'h05)
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // daa_irq_watchdog_control_checker

bind daa_irq_watchdog_control daa_irq_watchdog_control_checker #(
  .WDOG_LIMIT(WDOG_LIMIT), .LOOP_W(LOOP_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_ring_active(i_ring_active), .i_rx_overload(i_rx_overload),
  .i_frame_unlocked(i_frame_unlocked), .i_billing_tone(i_billing_tone),
  .i_supply_dropout(i_supply_dropout), .i_loop_current_field(i_loop_current_field),
  .i_tip_ground_status(i_tip_ground_status), .i_line_voltage_msb(i_line_voltage_msb),
  .o_irq_pin_select(o_irq_pin_select), .o_shared_audio_irq_pin(o_shared_audio_irq_pin),
  .o_hybrid_connect(o_hybrid_connect), .o_receive_path_on(o_receive_path_on),
  .o_offhook_ctrl(o_offhook_ctrl), .o_watchdog_on(o_watchdog_on));
`default_nettype wire

// ==== testbench/daa_host_model.sv ====
// host processor model driving the register port
// assumes the block takes a strobe on the rising edge it is high
`timescale 1ns/1ps
`default_nettype none

module daa_host_model (
  // clock
  input  wire logic       i_sys_clk,
  // register port toward the block
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata
);
  // idle bus at time zero
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // one access: raised after an edge, held across the taking edge
  // ---------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_reg_wr    = wr;
    o_reg_rd    = !wr;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    // released lines must not look like the last value
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  // answer is registered; it holds, so one more edge is safe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00);
    @(posedge i_sys_clk);
    #1;
    d = i_reg_rdata;
  endtask
endmodule // daa_host_model
`default_nettype wire

// ==== testbench/test_daa_irq_watchdog_control.sv ====
// self-checking bench for the control-two / mask / watchdog block
// assumes a short watchdog limit; events are same-clock levels
`timescale 1ns/1ps
`default_nettype none

module test_daa_irq_watchdog_control;
  localparam int LIMIT = 12;  // shortened idle span
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sel_bit, rd_val;
  logic [7:0] ev = 8'h00;  // event levels, flag bit order
  logic       pin_sel, pin, hyb, rx, offhook, wdog;
  int         fail_count = 0;
  int         comparisons = 0;

  always #20 sys_clk = ~sys_clk;  // 25 MHz

  daa_host_model host (.i_sys_clk(sys_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata));

  daa_irq_watchdog_control #(.WDOG_LIMIT(LIMIT), .LOOP_W(5)) DUT (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_ring_active(ev[7]), .i_rx_overload(ev[6]), .i_frame_unlocked(ev[5]),
    .i_billing_tone(ev[4]), .i_supply_dropout(ev[3]), .i_loop_current_field({ev[2], 4'hF}),
    .i_tip_ground_status(ev[1]), .i_line_voltage_msb(ev[0]),
    .o_irq_pin_select(pin_sel), .o_shared_audio_irq_pin(pin), .o_hybrid_connect(hyb),
    .o_receive_path_on(rx), .o_offhook_ctrl(offhook), .o_watchdog_on(wdog));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    cyc(6);
    sys_rst = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    host.reg_read(a, rd_val);
    check(what, rd_val, exp);
  endtask

  // pin is registered behind the flag, so let two edges pass
  task automatic pin_is(input logic e);
    cyc(2);
    check("pin", {7'h00, pin}, {7'h00, e});
  endtask

  task automatic pulse(input int i);
    cyc(1);
    ev[i] = 1'b1;
    cyc(1);
    ev[i] = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    check("outs", {2'b00, pin_sel, pin, hyb, rx, offhook, wdog}, 8'h00);
    rd_chk("ctl2", daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h00);
    rd_chk("mask", daa_ctrl_pkg::ADDR_IRQ_MASK, 8'h00);
    rd_chk("unmapped", 8'h07, 8'h00);
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'hEF);
    rd_chk("ctl2", daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'hC7);
    check("outs", {2'b00, pin_sel, pin, hyb, rx, offhook, wdog}, 8'h2C);
    // each source: masked, then unmasked while sticky, then cleared
    for (int i = 0; i < 8; i++) begin
      sel_bit = 8'h01 << i;
      host.reg_write(daa_ctrl_pkg::ADDR_IRQ_MASK, ~sel_bit);
      pulse(i);
      pin_is(1'b0);
      rd_chk("flags", daa_ctrl_pkg::ADDR_IRQ_SOURCE, sel_bit);
      host.reg_write(daa_ctrl_pkg::ADDR_IRQ_MASK, 8'hFF);
      pin_is(1'b1);
      host.reg_write(daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h00);
      pin_is(1'b0);
    end
    // active-low pin, audio mode with a pending flag
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h80);
    pin_is(1'b1);
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h00);
    pulse(7);
    pin_is(1'b0);
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h80);
    pin_is(1'b0);
    host.reg_write(daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h00);
    pin_is(1'b1);
    // one ring interrupt per burst, then two
    for (int m = 0; m < 2; m++) begin
      host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, (m == 1) ? 8'h84 : 8'h80);
      ev[7] = 1'b1;
      cyc(2);
      host.reg_write(daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h00);
      ev[7] = 1'b0;
      cyc(2);
      rd_chk("ring end", daa_ctrl_pkg::ADDR_IRQ_SOURCE, (m == 1) ? 8'h80 : 8'h00);
      pin_is(m == 1 ? 1'b0 : 1'b1);
      host.reg_write(daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h00);
    end
    // a falling top voltage bit alone must flag too
    ev[0] = 1'b1;
    cyc(2);
    host.reg_write(daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h00);
    ev[0] = 1'b0;
    rd_chk("fall", daa_ctrl_pkg::ADDR_IRQ_SOURCE, 8'h01);
    // watchdog: kept alive by reads, then left idle
    host.reg_write(daa_ctrl_pkg::ADDR_LINE_CONTROL, 8'h01);
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h10);
    repeat (4) begin
      cyc(LIMIT - 5);
      host.reg_read(daa_ctrl_pkg::ADDR_IRQ_MASK, rd_val);
    end
    check("offhook", {7'h00, offhook}, 8'h01);
    cyc(LIMIT + 6);
    check("offhook", {7'h00, offhook}, 8'h00);
    host.reg_write(daa_ctrl_pkg::ADDR_LINE_CONTROL, 8'h01);
    check("offhook", {7'h00, offhook}, 8'h01);
    host.reg_write(daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h00);
    rd_chk("ctl2", daa_ctrl_pkg::ADDR_CONTROL_TWO, 8'h10);
    do_reset();
    check("wdog", {7'h00, wdog}, 8'h00);
    conclude();
  end

  // hang guard: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    fail_count++;
    conclude();
  end
endmodule // test_daa_irq_watchdog_control
`default_nettype wire
